// ===== rtl/crcg_fold.sv
`timescale 1ns/100ps
module crcg_fold (
    crcg_fold_if.fold fi
);
    import crcg_pkg::*;

    // one shift step with conditional feedback
    function automatic logic [15:0] crcg_step(input logic [15:0] v, input logic [15:0] fb);
        logic [15:0] sh;
        sh = {v[14:0], 1'b0};
        crcg_step = v[15] ? (sh ^ fb) : sh;
    endfunction

    // whole byte unrolled combinationally so the result lands in one clock
    always_comb begin
        logic [15:0] t;
        logic [15:0] fb;
        t = 16'h0000;
        fb = fi.polynomial_select_sel ? CRCG_FB_CRC16 : CRCG_FB_CCITT;
        t = fi.sum_in ^ {fi.data_in, 8'h00};
        for (int i = 0; i < 8; i++) begin
            t = crcg_step(t, fb);
        end
        fi.sum_out = t;
    end
endmodule // crcg_fold

// ===== rtl/crcg_fold_if.sv
`timescale 1ns/100ps
interface crcg_fold_if;
    logic [15:0] sum_in;
    logic [7:0] data_in;
    logic polynomial_select_sel;
    logic [15:0] sum_out;
    modport core (output sum_in, output data_in, output polynomial_select_sel, input sum_out);
    modport fold (input sum_in, input data_in, input polynomial_select_sel, output sum_out);
endinterface // crcg_fold_if

// ===== rtl/crcg_pkg.sv
package crcg_pkg;

    // =========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [11:0] CRCG_OFS_INPUT = 12'h000;
    localparam logic [11:0] CRCG_OFS_SUM_LOW = 12'h004;
    localparam logic [11:0] CRCG_OFS_SUM_HIGH = 12'h008;
    localparam logic [11:0] CRCG_OFS_CONTROL = 12'h00C;

    // =========================================================
    // fields and reset values
    localparam int CRCG_POLYNOMIAL_SELECT_SEL_BIT = 0;
    localparam logic [7:0] CRCG_INPUT_RST = 8'h00;
    localparam logic [7:0] CRCG_SUM_LOW_RST = 8'h00;
    localparam logic [7:0] CRCG_SUM_HIGH_RST = 8'h00;
    localparam logic CRCG_POLYNOMIAL_SELECT_SEL_RST = 1'b0;

    // =========================================================
    // feedback constants
    localparam logic [15:0] CRCG_FB_CCITT = 16'h1021;
    localparam logic [15:0] CRCG_FB_CRC16 = 16'h8005;

    // =========================================================
    // timing: bus answers in the access cycle, so no wait states
    localparam int CRCG_CLK_HZ = 40000000;
    localparam int CRCG_UPDATE_CYCLES = 1;

    typedef enum logic [1:0] {
        CRCG_IDLE = 2'b00,
        CRCG_FOLD = 2'b01
    } crcg_state_t;

endpackage

// ===== rtl/crcg_top.sv
// Operation
// - every write of the input byte starts one checksum update with the current sum.
// - the 16-bit sum is held as a high byte and a low byte, both updated per byte.
// - control bit 0 picks the polynomial: 0 for CCITT, 1 for CRC-16.
// - feedback constant is 0x8005 for CRC-16 and 0x1021 for CCITT.
// - the byte is xored into the sum's upper byte with no bit reflection.
// - each step shifts left with zero in and xors the feedback when a one fell out.
// - eight steps per byte, msb first, and the final value becomes the new sum.
// - the new sum is readable within one instruction cycle of the input write.
// - only the two fixed polynomials exist; none is programmable.
// - software may write both sum bytes and clears them before a new run.
// - control bits 7 to 1 read as zero and ignore writes.
// - all four registers reset to zero and read back.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
module crcg_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] running_checksum
);
    import crcg_pkg::*;

    // =========================================================
    // registers
    logic [7:0] input_byte_reg;
    logic [7:0] sum_low_reg;
    logic [7:0] sum_high_reg;
    logic polynomial_select_sel_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic pready_reg;
    logic [15:0] checksum_out_reg;

    crcg_fold_if fold_bus ();

    crcg_fold u_fold (
        .fi(fold_bus)
    );

    // =========================================================
    // bus decode
    wire logic access = psel & penable;
    wire logic wr = access & pwrite & pstrb[0];
    wire logic hit_input = (paddr == CRCG_OFS_INPUT);
    wire logic hit_low = (paddr == CRCG_OFS_SUM_LOW);
    wire logic hit_high = (paddr == CRCG_OFS_SUM_HIGH);
    wire logic hit_ctrl = (paddr == CRCG_OFS_CONTROL);
    wire logic mapped = hit_input | hit_low | hit_high | hit_ctrl;
    wire logic wr_input = wr & hit_input;
    wire logic [7:0] wbyte = pwdata[7:0];

    // the fold sees the sum and select as they stand at the write edge
    assign fold_bus.sum_in = {sum_high_reg, sum_low_reg};
    assign fold_bus.data_in = wbyte;
    assign fold_bus.polynomial_select_sel = polynomial_select_sel_reg;

    wire logic [31:0] rd_mux =
        hit_input ? {24'h000000, input_byte_reg} :
        hit_low ? {24'h000000, sum_low_reg} :
        hit_high ? {24'h000000, sum_high_reg} :
        hit_ctrl ? {31'h0, polynomial_select_sel_reg} :
        32'h00000000;

    // =========================================================
    // register file and checksum update
    always_ff @(posedge core_clk) begin
        if (srst) begin
            input_byte_reg <= CRCG_INPUT_RST;
            sum_low_reg <= CRCG_SUM_LOW_RST;
            sum_high_reg <= CRCG_SUM_HIGH_RST;
            polynomial_select_sel_reg <= CRCG_POLYNOMIAL_SELECT_SEL_RST;
        end else begin
            if (wr_input) begin
                input_byte_reg <= wbyte;
                // fold finishes in the same edge as the write
                sum_high_reg <= fold_bus.sum_out[15:8];
                sum_low_reg <= fold_bus.sum_out[7:0];
            end
            if (wr & hit_low) begin
                sum_low_reg <= wbyte;
            end
            if (wr & hit_high) begin
                sum_high_reg <= wbyte;
            end
            if (wr & hit_ctrl) begin
                polynomial_select_sel_reg <= pwdata[CRCG_POLYNOMIAL_SELECT_SEL_BIT];
            end
        end
    end

    // =========================================================
    // bus answer: zero wait states, unmapped address gets pslverr
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b1;
        end else begin
            pready_reg <= 1'b1;
            prdata_reg <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
            pslverr_reg <= psel & ~penable & ~mapped;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            checksum_out_reg <= {CRCG_SUM_HIGH_RST, CRCG_SUM_LOW_RST};
        end else begin
            checksum_out_reg <= {sum_high_reg, sum_low_reg};
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    // ready in every access phase; registered setup path keeps prdata a flop
    assign pready = pready_reg;
    assign running_checksum = checksum_out_reg;

endmodule // crcg_top

// ===== test/crcg_apb_m.sv
`timescale 1ns/100ps
module crcg_apb_m (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic e);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, 24'h0, d, 4'hF};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // idle bus inverted so stale values never match
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~{24'h0, d}};
    endtask
endmodule // crcg_apb_m

// ===== test/crcg_chk.sv
`timescale 1ns/100ps
module crcg_chk import crcg_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] running_checksum
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire su = psel && !penable;
    wire wr = psel && penable && pwrite && pstrb[0];
    wire bad = |{paddr[11:4], paddr[1:0]};
    sequence s_quiet; !wr ##1 !wr; endsequence
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
    property p_err; su && bad |=> pslverr && (pwrite || prdata == 0); endproperty
    a_err: assert property (p_err) else $error("unmapped kept");
    property p_ok; su && !bad |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped refused");
    property p_ctl; su && !pwrite && paddr == CRCG_OFS_CONTROL |=> prdata[31:1] == 0; endproperty
    a_ctl: assert property (p_ctl) else $error("control high bits");
    property p_hi; su && !pwrite && paddr == CRCG_OFS_SUM_HIGH |=> prdata[31:8] == 0; endproperty
    a_hi: assert property (p_hi) else $error("high byte width");
    property p_hold; s_quiet |=> $stable(running_checksum); endproperty
    a_hold: assert property (p_hold) else $error("sum moved");
    property p_lo; wr && paddr == CRCG_OFS_SUM_LOW |-> ##2 running_checksum[7:0] == $past(pwdata[7:0], 2); endproperty
    a_lo: assert property (p_lo) else $error("low write");
    property p_hw; wr && paddr == CRCG_OFS_SUM_HIGH |-> ##2 running_checksum[15:8] == $past(pwdata[7:0], 2); endproperty
    a_hw: assert property (p_hw) else $error("high write");
endmodule // crcg_chk
bind crcg_top crcg_chk u_chk (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .running_checksum);

// ===== test/crcg_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, x, s) begin tests_run++; if ((s) !== (x)) begin n_errors++; $display("Error %s exp %h got %h", n, x, s); end end
module crcg_tb_top;
    import crcg_pkg::*;
    logic core_clk = 1'b0, srst = 1'b1, psel, penable, pwrite, pready, pslverr, e, polynomial_select;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [15:0] running_checksum, sum, w;
    logic [7:0] lf = 8'h2A;
    int n_errors = 0, tests_run = 0, cyc = 0;
    crcg_top DUT (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .running_checksum);
    crcg_apb_m u_m (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr);
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc > 8000) begin n_errors++; complete_run(); end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [15:0] crc_ref(input logic [15:0] s, input logic [7:0] b, input logic p);
        logic [15:0] t;
        t = s ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) t = {t[14:0], 1'b0} ^ (t[15] ? (p ? CRCG_FB_CRC16 : CRCG_FB_CCITT) : 16'h0);
        return t;
    endfunction
    task automatic xf(input logic wr, input logic [11:0] a, input logic [7:0] d);
        u_m.xfer(wr, a, d, r, e);
    endtask
    task automatic feed(input logic [7:0] d);
        xf(1'b1, CRCG_OFS_INPUT, d);
        sum = crc_ref(sum, d, polynomial_select);
        xf(1'b0, CRCG_OFS_SUM_HIGH, 8'h00);
        `CHK("high", {24'h0, sum[15:8]}, r)
        xf(1'b0, CRCG_OFS_SUM_LOW, 8'h00);
        `CHK("low", {24'h0, sum[7:0]}, r)
        `CHK("mirror", sum, running_checksum)
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        for (int a = 0; a < 20; a += 4) begin
            xf(1'b0, a[11:0], 8'h00);
            `CHK("reset", 32'h0, r)
            `CHK("slverr", a == 16, e)
        end
        for (int k = 0; k < 40; k++) begin
            lf = lfsr(lf);
            xf(1'b1, CRCG_OFS_CONTROL, k == 0 ? 8'hFF : lf);
            polynomial_select = k == 0 ? 1'b1 : lf[0];
            xf(1'b0, CRCG_OFS_CONTROL, 8'h00);
            `CHK("control", {31'h0, polynomial_select}, r)
            if (k % 8 == 0) begin
                sum = k == 0 ? 16'h0000 : {lf, lfsr(lf)};
                xf(1'b1, CRCG_OFS_SUM_LOW, sum[7:0]);
                xf(1'b1, CRCG_OFS_SUM_HIGH, sum[15:8]);
            end
            w = k == 1 ? 16'hFFFF : {lfsr(lf), ~lf};
            feed(w[7:0]);
            feed(w[15:8]);
        end
        // known four-byte stream from zero with ccitt
        polynomial_select = 1'b0;
        xf(1'b1, CRCG_OFS_CONTROL, 8'h00);
        sum = 16'h0000;
        xf(1'b1, CRCG_OFS_SUM_LOW, 8'h00);
        xf(1'b1, CRCG_OFS_SUM_HIGH, 8'h00);
        feed(8'h78);
        feed(8'h56);
        feed(8'h34);
        feed(8'h12);
        `CHK("vector", 16'hD0FA, running_checksum)
        complete_run();
    end
endmodule // crcg_tb_top
